// file: hdl/irps_map.vh
// register map, field positions, reset values and timing counts of the position sequencer
// ****************************************************************
// ****************************************************************
`ifndef IRPS_MAP_VH
`define IRPS_MAP_VH

// word offsets (byte addresses)
`define IRPS_OFS_MODE        8'h00
`define IRPS_OFS_MOVE_TYPE   8'h04
`define IRPS_OFS_MULTISTAGE  8'h08
`define IRPS_OFS_SOFT_TRIG   8'h0c
`define IRPS_OFS_FEEDBACK    8'h10
`define IRPS_OFS_STATUS      8'h14
`define IRPS_OFS_RAMP_BASE   8'h40
`define IRPS_OFS_RAMP_LAST   8'h7c

// values and fields
`define IRPS_MODE_INTERNAL   16'h0005
`define IRPS_MODE_RESET      16'h0000
`define IRPS_MOVE_RESET      16'h0000
`define IRPS_MULTI_RESET     16'h0020
`define IRPS_MULTI_EN_BIT    0
`define IRPS_RAMP_RESET      16'h0064
`define IRPS_RAMP_MAX        16'h7d00

// timing: one millisecond at 125 MHz
`define IRPS_CLK_MHZ         125
`define IRPS_MS_US           1000
`define IRPS_CYC_PER_MS      (`IRPS_CLK_MHZ * `IRPS_MS_US)

// status bits
`define IRPS_ST_BUSY         0
`define IRPS_ST_DECEL        1
`define IRPS_ST_ABS_ENC      2
`define IRPS_ST_USE_ENC_ABS  3
`define IRPS_ST_BATT_BLOCK   4
`define IRPS_ST_STAGE_LSB    8

`endif

// file: hdl/irps_ms_tick.v
// millisecond tick generator for ramp timing
`include "irps_map.vh"

module irps_ms_tick #(
    parameter CYC_PER_MS = `IRPS_CYC_PER_MS
) (
    input  wire clk,
    input  wire rst_b,
    output reg  tick
);
    reg [16:0] cnt;

    // free-running divider, one pulse per millisecond
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt  <= 17'h00000;
            tick <= 1'b0;
        end else if (cnt == CYC_PER_MS - 1) begin
            cnt  <= 17'h00000;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 17'h00001;
            tick <= 1'b0;
        end
    end
endmodule

// file: hdl/irps_ramp.v
// linear speed ramp: up over accel ms, hold, down over decel ms
module irps_ramp #(
    parameter SPD_W = 16
) (
    input  wire             clk,
    input  wire             rst_b,
    input  wire             start,
    input  wire             stop,
    input  wire             ms_tick,
    input  wire [15:0]      accel_ms,
    input  wire [15:0]      decel_ms,
    input  wire [SPD_W-1:0] max_speed,
    output reg  [SPD_W-1:0] speed,
    output reg              busy,
    output reg              decel
);
    localparam ST_IDLE = 2'd0;
    localparam ST_UP   = 2'd1;
    localparam ST_RUN  = 2'd2;
    localparam ST_DOWN = 2'd3;

    reg [1:0]       state;
    reg [15:0]      t_ms;
    reg [15:0]      acc_l;
    reg [15:0]      dec_l;
    reg [SPD_W-1:0] top;
    wire [SPD_W+15:0] up_prod = top * t_ms;
    wire [SPD_W+15:0] dn_prod = top * (dec_l - t_ms);
    wire [SPD_W+15:0] up_quo  = up_prod / acc_l; // below top while t_ms < acc_l
    wire [SPD_W+15:0] dn_quo  = dn_prod / dec_l; // below top once t_ms > 0

    // ramp state machine; times latched at start
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            t_ms  <= 16'h0000;
            acc_l <= 16'h0000;
            dec_l <= 16'h0000;
            top   <= {SPD_W{1'b0}};
            speed <= {SPD_W{1'b0}};
            busy  <= 1'b0;
            decel <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    speed <= {SPD_W{1'b0}};
                    decel <= 1'b0;
                    if (start) begin
                        acc_l <= accel_ms;
                        dec_l <= decel_ms;
                        top   <= max_speed;
                        t_ms  <= 16'h0000;
                        busy  <= 1'b1;
                        state <= ST_UP;
                    end
                end
                ST_UP: begin
                    if (stop) begin
                        top   <= speed; // ramp down from where the rise was cut
                        t_ms  <= 16'h0000;
                        decel <= 1'b1;
                        state <= ST_DOWN;
                    end else if (t_ms >= acc_l) begin
                        speed <= top;
                        t_ms  <= 16'h0000;
                        state <= ST_RUN;
                    end else begin
                        speed <= up_quo[SPD_W-1:0];
                        if (ms_tick) begin
                            t_ms <= t_ms + 16'h0001;
                        end
                    end
                end
                ST_RUN: begin
                    speed <= top;
                    if (stop) begin
                        t_ms  <= 16'h0000;
                        decel <= 1'b1;
                        state <= ST_DOWN;
                    end
                end
                default: begin
                    if (t_ms >= dec_l) begin
                        speed <= {SPD_W{1'b0}};
                        busy  <= 1'b0;
                        decel <= 1'b0;
                        state <= ST_IDLE;
                    end else begin
                        speed <= dn_quo[SPD_W-1:0];
                        if (ms_tick) begin
                            t_ms <= t_ms + 16'h0001;
                        end
                    end
                end
            endcase
        end
    end
endmodule

// file: hdl/irps_top.v
// internal register position sequencer: wishbone registers, start logic, ramp
`include "irps_map.vh"

module irps_top #(
    parameter ABS_ENCODER = 1,
    parameter SPD_W       = 16,
    parameter CYC_PER_MS  = `IRPS_CYC_PER_MS
) (
    input  wire             clk,
    input  wire             rst_b,
    input  wire             wb_cyc_i,
    input  wire             wb_stb_i,
    input  wire             wb_we_i,
    input  wire [7:0]       wb_adr_i,
    input  wire [3:0]       wb_sel_i,
    input  wire [31:0]      wb_dat_i,
    output reg  [31:0]      wb_dat_o,
    output reg              wb_ack_o,
    input  wire [2:0]       stage_select_inputs,
    input  wire             hardware_start_trigger,
    input  wire             stop_request,
    input  wire [SPD_W-1:0] stage_max_speed,
    output reg              internal_mode_active,
    output reg              move_absolute,
    output reg              use_encoder_abs,
    output reg              battery_block,
    output reg              multistage_enable,
    output reg  [2:0]       active_stage,
    output reg              move_start,
    output reg              move_busy,
    output reg  [SPD_W-1:0] speed_cmd
);
    // ****************************************************************
    // register file
    // ****************************************************************
    reg  [15:0] control_mode_select;
    reg  [15:0] move_type_select;
    reg  [15:0] multistage_setup;
    reg  [15:0] soft_start_trigger;
    reg  [15:0] feedback_select;
    reg  [15:0] accel_time [0:7];
    reg  [15:0] decel_time [0:7];
    reg         trig_prev;
    reg  [2:0]  stage_l;

    wire        ramp_busy;
    wire        ramp_decel;
    wire [SPD_W-1:0] ramp_speed;
    wire        ms_tick;

    wire        wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        wb_wr    = wb_req && wb_we_i;
    wire        ramp_hit = (wb_adr_i >= `IRPS_OFS_RAMP_BASE) &&
                           (wb_adr_i <= `IRPS_OFS_RAMP_LAST) && (wb_adr_i[1:0] == 2'b00);
    wire [3:0]  ramp_idx = wb_adr_i[5:2];
    wire [2:0]  ramp_stg = ramp_idx[3:1];

    // byte-lane merge of a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] dat;
        input [3:0]  sel;
        begin
            merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
        end
    endfunction

    // clamp a ramp time to its legal range
    function [15:0] clamp_ms;
        input [15:0] v;
        begin
            clamp_ms = (v > `IRPS_RAMP_MAX) ? `IRPS_RAMP_MAX : v;
        end
    endfunction

    // start sources and conditions
    wire mode_ok   = (control_mode_select == `IRPS_MODE_INTERNAL);
    wire hw_edge   = hardware_start_trigger && !trig_prev;
    wire soft_go   = soft_start_trigger[0];
    wire start_req = mode_ok && (hw_edge || soft_go) && !ramp_busy;
    wire stop_now  = stop_request || !mode_ok;

    // wishbone slave: one-cycle ack, writes and trigger self-clear
    integer i;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o            <= 1'b0;
            control_mode_select <= `IRPS_MODE_RESET;
            move_type_select    <= `IRPS_MOVE_RESET;
            multistage_setup    <= `IRPS_MULTI_RESET;
            soft_start_trigger  <= 16'h0000;
            feedback_select     <= 16'h0000;
            for (i = 0; i < 8; i = i + 1) begin
                accel_time[i] <= `IRPS_RAMP_RESET;
                decel_time[i] <= `IRPS_RAMP_RESET;
            end
        end else begin
            wb_ack_o <= wb_req;
            // trigger clears the cycle after it is set, whether it starts a move or not; a new write of 1 in that cycle wins
            if (soft_go && (start_req || !mode_ok || ramp_busy)) begin
                soft_start_trigger <= 16'h0000;
            end
            if (wb_wr) begin
                case (wb_adr_i)
                    `IRPS_OFS_MODE:
                        control_mode_select <= merge16(control_mode_select, wb_dat_i, wb_sel_i);
                    `IRPS_OFS_MOVE_TYPE:
                        move_type_select <= merge16(move_type_select, wb_dat_i, wb_sel_i);
                    `IRPS_OFS_MULTISTAGE:
                        multistage_setup <= merge16(multistage_setup, wb_dat_i, wb_sel_i);
                    `IRPS_OFS_SOFT_TRIG: begin
                        if (wb_sel_i[0] && wb_dat_i[0]) begin
                            soft_start_trigger <= 16'h0001;
                        end
                    end
                    `IRPS_OFS_FEEDBACK:
                        feedback_select <= merge16(feedback_select, wb_dat_i, wb_sel_i);
                    default: begin
                        if (ramp_hit && !ramp_idx[0]) begin
                            accel_time[ramp_stg] <= clamp_ms(merge16(accel_time[ramp_stg],
                                wb_dat_i, wb_sel_i));
                        end else if (ramp_hit) begin
                            decel_time[ramp_stg] <= clamp_ms(merge16(decel_time[ramp_stg],
                                wb_dat_i, wb_sel_i));
                        end
                    end
                endcase
            end
        end
    end

    // read data mux; unmapped reads return zero
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `IRPS_OFS_MODE:       wb_dat_o <= {16'h0000, control_mode_select};
                `IRPS_OFS_MOVE_TYPE:  wb_dat_o <= {16'h0000, move_type_select};
                `IRPS_OFS_MULTISTAGE: wb_dat_o <= {16'h0000, multistage_setup};
                `IRPS_OFS_SOFT_TRIG:  wb_dat_o <= {16'h0000, soft_start_trigger};
                `IRPS_OFS_FEEDBACK:   wb_dat_o <= {16'h0000, feedback_select};
                `IRPS_OFS_STATUS:     wb_dat_o <= {21'h00000, active_stage, 3'h0,
                                                   battery_block, use_encoder_abs,
                                                   (ABS_ENCODER != 0), ramp_decel, ramp_busy};
                default: begin
                    if (ramp_hit && !ramp_idx[0]) begin
                        wb_dat_o <= {16'h0000, accel_time[ramp_stg]};
                    end else if (ramp_hit) begin
                        wb_dat_o <= {16'h0000, decel_time[ramp_stg]};
                    end else begin
                        wb_dat_o <= 32'h00000000;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // start control
    // ****************************************************************
    // stage latch and start pulse
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trig_prev  <= 1'b0;
            stage_l    <= 3'h0;
            move_start <= 1'b0;
        end else begin
            trig_prev  <= hardware_start_trigger;
            move_start <= start_req;
            if (start_req) begin
                stage_l <= stage_select_inputs;
            end
        end
    end

    // ramp times of the selected stage, read live for the next start
    wire [15:0] sel_accel = accel_time[stage_select_inputs];
    wire [15:0] sel_decel = decel_time[stage_select_inputs];

    // ****************************************************************
    // ramp and timing
    // ****************************************************************
    irps_ms_tick #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_tick (
        .clk   (clk),
        .rst_b (rst_b),
        .tick  (ms_tick)
    );

    irps_ramp #(
        .SPD_W (SPD_W)
    ) u_ramp (
        .clk       (clk),
        .rst_b     (rst_b),
        .start     (start_req),
        .stop      (stop_now),
        .ms_tick   (ms_tick),
        .accel_ms  (sel_accel),
        .decel_ms  (sel_decel),
        .max_speed (stage_max_speed),
        .speed     (ramp_speed),
        .busy      (ramp_busy),
        .decel     (ramp_decel)
    );

    // registered status outputs
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            internal_mode_active <= 1'b0;
            move_absolute        <= 1'b0;
            use_encoder_abs      <= 1'b0;
            battery_block        <= 1'b0;
            multistage_enable    <= 1'b0;
            active_stage         <= 3'h0;
            move_busy            <= 1'b0;
            speed_cmd            <= {SPD_W{1'b0}};
        end else begin
            internal_mode_active <= mode_ok;
            move_absolute        <= move_type_select[0];
            use_encoder_abs      <= (ABS_ENCODER != 0) && move_type_select[0]
                                    && !feedback_select[0];
            battery_block        <= (ABS_ENCODER != 0) && feedback_select[0];
            multistage_enable    <= multistage_setup[`IRPS_MULTI_EN_BIT];
            active_stage         <= stage_l;
            move_busy            <= ramp_busy;
            speed_cmd            <= ramp_speed;
        end
    end
endmodule

// file: verif/irps_chk.sv
// port checker for the position sequencer
// ****************************************
// checks
// ****************************************
module irps_chk #(
    parameter SPD_W = 16
) (
    input logic             clk,
    input logic             rst_b,
    input logic             wb_cyc_i,
    input logic             wb_stb_i,
    input logic             wb_we_i,
    input logic [7:0]       wb_adr_i,
    input logic [31:0]      wb_dat_i,
    input logic             wb_ack_o,
    input logic [2:0]       stage_select_inputs,
    input logic             hardware_start_trigger,
    input logic             internal_mode_active,
    input logic             move_absolute,
    input logic             multistage_enable,
    input logic [2:0]       active_stage,
    input logic             move_start,
    input logic             move_busy,
    input logic [SPD_W-1:0] speed_cmd
);
    // write seen at its acknowledging edge
    wire [15:0] wd = wb_dat_i[15:0];
    wire        d0 = wb_dat_i[0];
    wire        wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    mode_decode_a: assert property (
        wr && wb_adr_i == 8'h00 |-> ##2 internal_mode_active == ($past(wd, 2) == 16'h0005))
        else $error("mode flag wrong after write");
    move_kind_a: assert property (
        wr && wb_adr_i == 8'h04 |-> ##2 move_absolute == $past(d0, 2))
        else $error("move kind flag wrong after write");
    multi_enable_a: assert property (
        wr && wb_adr_i == 8'h08 |-> ##2 multistage_enable == $past(d0, 2))
        else $error("multistage flag wrong after write");
    ack_latency_a: assert property ($rose(wb_stb_i) |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    start_pulse_a: assert property (move_start |=> !move_start)
        else $error("start pulse too long");
    start_mode_a: assert property (move_start |-> internal_mode_active)
        else $error("start outside internal mode");
    start_idle_a: assert property (move_start |-> !move_busy ##1 move_busy)
        else $error("start while busy or busy missing");
    hw_start_a: assert property (
        $rose(hardware_start_trigger) && internal_mode_active && !move_busy && !move_start
        |=> move_start) else $error("trigger edge gave no start");
    stage_latch_a: assert property (
        move_start |=> active_stage == $past(stage_select_inputs, 2))
        else $error("stage code not latched");
    idle_speed_a: assert property (!move_busy && !$past(move_busy) |-> speed_cmd == 0)
        else $error("speed while idle");
endmodule
bind irps_top irps_chk #(.SPD_W(SPD_W)) i_irps_chk (.clk(clk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .stage_select_inputs(stage_select_inputs),
    .hardware_start_trigger(hardware_start_trigger), .move_start(move_start),
    .internal_mode_active(internal_mode_active), .move_absolute(move_absolute),
    .multistage_enable(multistage_enable), .active_stage(active_stage),
    .move_busy(move_busy), .speed_cmd(speed_cmd));

// file: verif/irps_host_model.sv
// host model: presents a stage code, then pulses the start contact
module irps_host_model (
    input  logic        clk,
    input  logic        req_go,
    input  logic [2:0]  req_stage,
    input  logic [3:0]  req_lag,
    input  logic        req_stop,
    input  logic [15:0] req_speed,
    output logic [2:0]  stage_select_inputs,
    output logic        hardware_start_trigger,
    output logic        stop_request,
    output logic [15:0] stage_max_speed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt = 5'h00;
    initial begin
        stage_select_inputs = 3'h0;
        hardware_start_trigger = 1'b0;
        stop_request = 1'b0;
        stage_max_speed = 16'h0000;
    end
    // stage first, trigger after the lag, held two cycles
    always @(posedge clk) begin
        stop_request <= req_stop;
        stage_max_speed <= req_speed;
        if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
            hardware_start_trigger <= (cnt < 5'h03);
        end else begin
            hardware_start_trigger <= 1'b0;
            if (req_go) begin
                stage_select_inputs <= req_stage;
                cnt <= {1'b0, req_lag} + 5'h03;
            end
        end
    end
endmodule

// file: verif/irps_tb.sv
// self-checking bench for the position sequencer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
`include "irps_map.vh"
    localparam int CPM = 10;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rd;
    logic        go = 1'b0;
    logic        stop = 1'b0;
    logic [2:0]  stg = 3'h0;
    logic [3:0]  lag = 4'h0;
    logic [15:0] spd = 16'h0040;
    wire  [31:0] dat_o;
    wire         ack, trig, stopr, mode_act, mabs, uenc, batt, mst_en, mstart, busy;
    wire  [2:0]  ssi, act_stage;
    wire  [15:0] smax, speed;
    int          mismatches = 0;
    int          compares = 0;
    int          starts = 0;
    irps_top #(.CYC_PER_MS(CPM)) i_irps_top (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .stage_select_inputs(ssi),
        .hardware_start_trigger(trig), .stop_request(stopr), .stage_max_speed(smax),
        .internal_mode_active(mode_act), .move_absolute(mabs), .use_encoder_abs(uenc),
        .battery_block(batt), .multistage_enable(mst_en), .active_stage(act_stage),
        .move_start(mstart), .move_busy(busy), .speed_cmd(speed));
    irps_host_model i_irps_host_model (.clk(clk), .req_go(go), .req_stage(stg),
        .req_lag(lag), .req_stop(stop), .req_speed(spd), .stage_select_inputs(ssi),
        .hardware_start_trigger(trig), .stop_request(stopr), .stage_max_speed(smax));
    // clock and start counter
    initial forever #4 clk = ~clk;
    always @(posedge clk) if (mstart === 1'b1) starts++;
    task automatic wrap_up;
        $display("counts: %0d mismatches, %0d compares", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic bit hit(input int w);
        return w == 0 ? mstart === 1'b1 : w == 1 ? speed === spd : busy === 1'b0;
    endfunction
    // bounded wait for a start, peak speed or idle
    task automatic meas(input int w, input int lim, output int c);
        c = 0;
        while (!hit(w) && c < lim) begin
            @(posedge clk);
            c++;
        end
        if (!hit(w)) begin
            chk(32'h0, 32'h1);
            wrap_up();
        end
    endtask
    // one classic wishbone cycle, held until ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h3;
        wdat <= {16'h0000, d};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (ack !== 1'b1) begin
            chk(32'h0, 32'h1);
            wrap_up();
        end
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
        repeat (3) @(posedge clk);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 16'h0000);
        chk(rd, exp);
    endtask
    task automatic host_go(input logic [2:0] s, input logic [3:0] l);
        @(posedge clk);
        stg <= s;
        lag <= l;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic halt(output int c);
        @(posedge clk);
        stop <= 1'b1;
        meas(2, 3000, c);
        stop <= 1'b0;
    endtask
    task automatic t_reset_vals;
        rreg(`IRPS_OFS_MODE, 32'h0);
        rreg(`IRPS_OFS_MULTISTAGE, 32'h20);
        rreg(`IRPS_OFS_SOFT_TRIG, 32'h0);
        for (int i = 0; i < 16; i++) rreg(`IRPS_OFS_RAMP_BASE + 8'(4 * i), 32'h64);
        rreg(8'h30, 32'h0);
    endtask
    task automatic t_config;
        wr(`IRPS_OFS_MOVE_TYPE, 16'h0001);
        chk(mabs, 1'b1);
        wr(`IRPS_OFS_FEEDBACK, 16'h0000);
        chk({uenc, batt}, 2'h2);
        wr(`IRPS_OFS_FEEDBACK, 16'h0001);
        chk({uenc, batt}, 2'h1);
        wr(`IRPS_OFS_MOVE_TYPE, 16'h0000);
        chk(mabs, 1'b0);
        wr(`IRPS_OFS_MULTISTAGE, 16'h0021);
        chk(mst_en, 1'b1);
        wr(`IRPS_OFS_MULTISTAGE, 16'h0020);
        chk(mst_en, 1'b0);
        wr(8'h7c, 16'hffff);
        rreg(8'h7c, 32'h7d00);
    endtask
    task automatic t_mode;
        int s;
        s = starts;
        wr(`IRPS_OFS_MODE, 16'h0003);
        chk(mode_act, 1'b0);
        host_go(3'h2, 4'h0);
        repeat (10) @(posedge clk);
        wr(`IRPS_OFS_SOFT_TRIG, 16'h0001);
        rreg(`IRPS_OFS_SOFT_TRIG, 32'h0);
        chk(starts, s);
        wr(`IRPS_OFS_MODE, 16'h0005);
        chk(mode_act, 1'b1);
    endtask
    task automatic t_soft;
        int s, c;
        s = starts;
        wr(`IRPS_OFS_SOFT_TRIG, 16'h0000);
        repeat (10) @(posedge clk);
        chk(starts, s);
        wr(`IRPS_OFS_SOFT_TRIG, 16'h0001);
        repeat (10) @(posedge clk);
        chk(starts, s + 1);
        rreg(`IRPS_OFS_SOFT_TRIG, 32'h0);
        chk(busy, 1'b1);
        rreg(`IRPS_OFS_STATUS, 32'h215);
        halt(c);
    endtask
    // stage 7 ramps; a changed accel time applies to the next start
    task automatic t_ramp;
        int a, c;
        wr(8'h7c, 16'h0002);
        for (int i = 0; i < 2; i++) begin
            a = (i == 0) ? 6 : 1;
            wr(8'h78, 16'(a));
            host_go(3'h7, 4'(5 * (1 - i)));
            meas(0, 40, c);
            meas(1, 100, c);
            chk(c >= (a - 1) * CPM && c <= (a + 1) * CPM + 2, 1'b1);
            chk(act_stage, 3'h7);
            halt(c);
            chk(c >= CPM && c <= 3 * CPM + 2, 1'b1);
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_vals();
        t_config();
        t_mode();
        t_soft();
        t_ramp();
        wrap_up();
    end
endmodule
